/* File: hdl/hmb_counter.sv */
// Eight-bit message counter bumped after each completed transfer
`timescale 1ns/1ps
`include "hmb_defs.svh"
module hmb_counter
  import hmb_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic bump,
  output logic [7:0] count
);
  hmb_cnt_state_t state_reg;
  hmb_cnt_state_t state_next;

  // Wraps at 255; one step per finished transfer
  always_comb begin
    state_next = state_reg;
    if (bump) begin
      state_next.count = state_reg.count + 8'h01;
    end
  end

  // Counter flop
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign count = state_reg.count;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  chk_counter_wrap: assert property ((state_reg.count == 8'hFF) && bump |=>
    state_reg.count == 8'h00) else $error("message counter did not wrap");
endmodule

/* File: hdl/hmb_snapshot.sv */
// Snapshot store holding the sixteen message words of one transfer
`timescale 1ns/1ps
module hmb_snapshot
  import hmb_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  hmb_if.store hm
);
  hmb_snap_state_t state_reg;
  hmb_snap_state_t state_next;

  // Whole message taken in one edge so a transfer never mixes two samples
  always_comb begin
    state_next = state_reg;
    if (hm.capture) begin
      state_next.mem = hm.live;
    end
  end

  // Storage
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Indexed reads for the transmitter and for software
  assign hm.word = state_reg.mem[hm.idx];
  assign hm.reg_word = state_reg.mem[hm.reg_idx];
endmodule

/* File: hdl/hmb_top.sv */
// Health message builder: packs, snapshots and streams the sixteen-word message
// How it works
// - Message is sixteen 16-bit words, always ready in every mode.
// - Multi-byte fields big-endian: high byte upper half, high word first.
// - Word zero: status byte high, message counter low.
// - Words one to five: the five temperatures in fixed order.
// - Word six: cooler current high byte, cooler voltage low byte.
// - Words seven to ten: supply voltages then currents, byte pairs.
// - Words 11-12 timestamp, 13-14 CPU monitor bytes, 15 spare.
// - Status byte: type, polarity, power, low temp, error, mode.
// - Type is 00 standard or 11 safe, never 01 or 10.
// - Polarity flag is 1 while cooling, 0 while heating.
// - Power flag is 1 when sensor powered and heater off.
// - Low-temperature flag set while sensor board below threshold.
// - Error flag makes first three CPU monitor bytes an error report.
// - Mode 00 standby, 01 preparation, 10 measurement, never 11.
// - Error report: timestamp 31:24, timestamp 23:16, then error code.
// - Counter advances after each transfer, within 10 ms.
// - Fetch is a transmit to terminal 11001, count 16; status then data.
`timescale 1ns/1ps
`include "hmb_defs.svh"
module hmb_top
  import hmb_pkg::*;
#(
  parameter int LAT_CYCLES = `HMB_LAT_MS * `HMB_CLK_KHZ
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic cmd_valid,
  input wire logic [15:0] cmd_word,
  input wire logic tx_ready,
  output logic tx_valid,
  output logic [15:0] tx_data,
  output logic tx_last,
  input wire logic [15:0] photodiode_array_temp,
  input wire logic [15:0] cooling_console_temp,
  input wire logic [15:0] quartz_body_temp,
  input wire logic [15:0] sensor_board_temp,
  input wire logic [15:0] power_board_temp,
  input wire logic [7:0] cooler_current,
  input wire logic [7:0] cooler_voltage,
  input wire logic [7:0] digital_5v_voltage,
  input wire logic [7:0] analog_5v_voltage,
  input wire logic [7:0] rail_3v3_voltage,
  input wire logic [7:0] rail_1v5_voltage,
  input wire logic [7:0] digital_5v_current,
  input wire logic [7:0] analog_5v_current,
  input wire logic [7:0] rail_3v3_current,
  input wire logic [7:0] rail_1v5_current,
  input wire logic [31:0] timestamp,
  input wire logic [7:0] cpu_monitor_byte_1,
  input wire logic [7:0] cpu_monitor_byte_2,
  input wire logic [7:0] cpu_monitor_byte_4,
  input wire logic err_event,
  input wire logic [7:0] err_code,
  output logic [7:0] message_counter
);
  hmb_top_state_t state_reg;
  hmb_top_state_t state_next;
  hmb_if hm();
  logic cmd_ok;
  logic low_temp;
  logic [7:0] status_byte;
  logic [1:0] msg_type;
  logic [7:0] count_now;
  hmb_word_t status_word;

  // Byte pair in bus order, more significant byte in the upper half
  function automatic hmb_word_t pack2(input logic [7:0] hi, input logic [7:0] lo);
    pack2 = {hi, lo};
  endfunction

  // True for a transmit of sixteen words to our terminal on a message subaddress
  function automatic logic cmd_match(input logic [15:0] w);
    logic sa_ok;
    sa_ok = (w[9:5] == `HMB_SUBADDR_A) || (w[9:5] == `HMB_SUBADDR_B);
    cmd_match = (w[15:11] == `HMB_RT_ADDR) && w[10] && sa_ok &&
      (w[4:0] == `HMB_WORD_COUNT);
  endfunction

  // Store and counter
  hmb_snapshot u_snap (
    .clk(clk),
    .arst_n(arst_n),
    .hm(hm)
  );

  hmb_counter u_cnt (
    .clk(clk),
    .arst_n(arst_n),
    .bump(state_reg.done),
    .count(message_counter)
  );

  // Status byte; type is one control bit so the undefined codes cannot arise
  assign low_temp = sensor_board_temp < state_reg.thresh;
  assign msg_type = state_reg.safe ? `HMB_TYPE_SAFE : `HMB_TYPE_STD;
  assign status_byte = {msg_type, state_reg.tec_cool, state_reg.isu_pwr,
    low_temp, state_reg.err, state_reg.mode};
  assign status_word = {`HMB_RT_ADDR, 11'h000};
  // A fetch taken in the cycle the counter bumps must carry the new count
  assign count_now = message_counter + {7'h00, state_reg.done};
  assign cmd_ok = cmd_valid && cmd_match(cmd_word);

  // Live message layout, sampled into the store at each accepted fetch
  assign hm.live[0] = pack2(status_byte, count_now);
  assign hm.live[1] = photodiode_array_temp;
  assign hm.live[2] = cooling_console_temp;
  assign hm.live[3] = quartz_body_temp;
  assign hm.live[4] = sensor_board_temp;
  assign hm.live[5] = power_board_temp;
  assign hm.live[6] = pack2(cooler_current, cooler_voltage);
  assign hm.live[7] = pack2(digital_5v_voltage, analog_5v_voltage);
  assign hm.live[8] = pack2(rail_3v3_voltage, rail_1v5_voltage);
  assign hm.live[9] = pack2(digital_5v_current, analog_5v_current);
  assign hm.live[10] = pack2(rail_3v3_current, rail_1v5_current);
  assign hm.live[11] = timestamp[31:16];
  assign hm.live[12] = timestamp[15:0];
  // Error report displaces the ordinary CPU bytes while the flag stands
  assign hm.live[13] = state_reg.err ? state_reg.err_ts :
    pack2(cpu_monitor_byte_1, cpu_monitor_byte_2);
  assign hm.live[14] = pack2(state_reg.err ? state_reg.err_code : 8'h00,
    cpu_monitor_byte_4);
  assign hm.live[15] = 16'h0000;

  // Snapshot taken only when idle so a busy store is never overwritten
  assign hm.capture = cmd_ok && (state_reg.st == HMB_IDLE);
  assign hm.idx = (state_reg.st == HMB_DATA) ? (state_reg.idx + 4'h1) : 4'h0;
  assign hm.reg_idx = reg_addr[5:2];

  // Next state: transmitter, register writes, error capture, read data
  always_comb begin
    state_next = state_reg;
    state_next.done = 1'b0;
    state_next.rd_data = 32'h0000_0000;
    case (state_reg.st)
      HMB_IDLE: begin
        if (hm.capture) begin
          state_next.st = HMB_STAT;
          state_next.tx_valid = 1'b1;
          state_next.tx_data = status_word;
          state_next.tx_last = 1'b0;
          state_next.idx = 4'h0;
        end
      end
      HMB_STAT: begin
        if (tx_ready) begin
          state_next.st = HMB_DATA;
          state_next.tx_data = hm.word;
          state_next.idx = 4'h0;
        end
      end
      HMB_DATA: begin
        if (tx_ready) begin
          if (state_reg.idx == `HMB_LAST_IDX) begin
            // Sixteenth data word taken: transfer over, counter bumps next
            state_next.st = HMB_IDLE;
            state_next.tx_valid = 1'b0;
            state_next.tx_last = 1'b0;
            state_next.tx_data = 16'h0000;
            state_next.done = 1'b1;
          end else begin
            state_next.idx = hm.idx;
            state_next.tx_data = hm.word;
            state_next.tx_last = (hm.idx == `HMB_LAST_IDX);
          end
        end
      end
      default: begin
        state_next.st = HMB_IDLE;
        state_next.tx_valid = 1'b0;
        state_next.tx_last = 1'b0;
      end
    endcase
    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        `HMB_OFF_CTRL: begin
          // Undefined mode code is dropped, previous mode kept
          if (reg_wdata[`HMB_CTRL_MODE_LSB +: 2] != `HMB_MODE_BAD) begin
            state_next.mode = reg_wdata[`HMB_CTRL_MODE_LSB +: 2];
          end
          state_next.safe = reg_wdata[`HMB_CTRL_SAFE_BIT];
          state_next.tec_cool = reg_wdata[`HMB_CTRL_TEC_BIT];
          state_next.isu_pwr = reg_wdata[`HMB_CTRL_ISU_BIT];
        end
        `HMB_OFF_THRESH: begin
          state_next.thresh = reg_wdata[15:0];
        end
        `HMB_OFF_STATUS: begin
          if (reg_wdata[`HMB_STATUS_ERR_BIT]) begin
            state_next.err = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    // New error after the clear so a same-cycle event survives
    if (err_event) begin
      state_next.err = 1'b1;
      state_next.err_code = err_code;
      state_next.err_ts = timestamp[31:16];
    end
    // Read data for exactly the cycle after the strobe
    if (reg_rd) begin
      case (reg_addr)
        `HMB_OFF_CTRL: begin
          state_next.rd_data = {27'h0, state_reg.isu_pwr, state_reg.tec_cool,
            state_reg.safe, state_reg.mode};
        end
        `HMB_OFF_THRESH: begin
          state_next.rd_data = {16'h0000, state_reg.thresh};
        end
        `HMB_OFF_STATUS: begin
          state_next.rd_data = {22'h0, (state_reg.st != HMB_IDLE), state_reg.err,
            message_counter};
        end
        `HMB_OFF_ERRCODE: begin
          state_next.rd_data = {state_reg.err_ts, 8'h00, state_reg.err_code};
        end
        default: begin
          if (reg_addr[7:6] == `HMB_MSG_SEL) begin
            state_next.rd_data = {16'h0000, hm.reg_word};
          end
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= '0;
      state_reg.st <= HMB_IDLE;
      state_reg.mode <= `HMB_MODE_STANDBY_STATE;
      state_reg.thresh <= `HMB_THRESH_RST;
      state_reg.err_code <= `HMB_ERRCODE_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from flops
  assign reg_rdata = state_reg.rd_data;
  assign tx_valid = state_reg.tx_valid;
  assign tx_data = state_reg.tx_data;
  assign tx_last = state_reg.tx_last;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // Checking helpers: data words per transfer, cycles waiting for the counter
  logic [4:0] chk_words;
  logic [31:0] chk_wait;
  logic [7:0] chk_cnt_seen;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      chk_words <= 5'h00;
      chk_wait <= 32'h0000_0000;
      chk_cnt_seen <= 8'h00;
    end else begin
      chk_cnt_seen <= message_counter;
      if (hm.capture) begin
        chk_words <= 5'h00;
      end else if ((state_reg.st == HMB_DATA) && tx_ready) begin
        chk_words <= chk_words + 5'h01;
      end
      // Waiting stops once the counter has moved, else it would grow forever
      if (state_reg.done) begin
        chk_wait <= 32'h0000_0001;
      end else if ((chk_wait != 32'h0) && (message_counter == chk_cnt_seen)) begin
        chk_wait <= chk_wait + 32'h1;
      end else begin
        chk_wait <= 32'h0000_0000;
      end
    end
  end

  chk_word_total: assert property (state_reg.done |-> chk_words == 5'h10)
    else $error("transfer did not carry sixteen data words");
  chk_type_legal: assert property ((hm.live[0][15:14] == `HMB_TYPE_STD) ||
    (hm.live[0][15:14] == `HMB_TYPE_SAFE)) else $error("undefined message type");
  chk_mode_legal: assert property (state_reg.mode != `HMB_MODE_BAD)
    else $error("undefined mode code held");
  chk_status_snap: assert property (hm.capture |=> hm.word[15:8] ==
    {$past(msg_type), $past(state_reg.tec_cool), $past(state_reg.isu_pwr),
    $past(low_temp), $past(state_reg.err), $past(state_reg.mode)})
    else $error("snapshot status byte differs from state at capture");
  chk_low_temp: assert property (hm.capture |=> hm.word[11] ==
    ($past(sensor_board_temp) < $past(state_reg.thresh)))
    else $error("low temperature flag wrong");
  chk_err_report: assert property (err_event |=> (hm.live[13] ==
    $past(timestamp[31:16])) && (hm.live[14][15:8] == $past(err_code)))
    else $error("error report not in CPU monitor bytes");
  chk_counter_step: assert property (state_reg.done |-> ##1 message_counter ==
    $past(message_counter) + 8'h01) else $error("counter not advanced after transfer");
  chk_counter_late: assert property (chk_wait < LAT_CYCLES)
    else $error("counter update too late");
  chk_status_word: assert property ((state_reg.st == HMB_STAT) |->
    tx_valid && (tx_data == {`HMB_RT_ADDR, 11'h000})) else $error("bad status word");
  chk_spare_zero: assert property (tx_last |-> tx_data == 16'h0000)
    else $error("spare word not zero");
  chk_tx_hold: assert property (tx_valid && !tx_ready |=>
    tx_valid && $stable(tx_data)) else $error("offered word changed before it was taken");
  chk_counter_in_msg: assert property ((state_reg.st == HMB_STAT) && tx_ready |=>
    tx_data[7:0] == message_counter) else $error("word zero lacks counter");

  cov_full_fetch: cover property (hm.capture ##[1:40] state_reg.done);
  cov_busy_refused: cover property ((state_reg.st != HMB_IDLE) && cmd_ok);
  cov_err_clear_race: cover property (err_event && reg_wr &&
    (reg_addr == `HMB_OFF_STATUS));
  cov_safe_fetch: cover property (state_reg.safe && hm.capture);
  cov_slow_accept: cover property ((state_reg.st == HMB_DATA) && !tx_ready);
endmodule

/* File: pkg/hmb_defs.svh */
// Constants of the health message builder: offsets, fields, codes, timing
`ifndef HMB_DEFS_SVH
`define HMB_DEFS_SVH
// Register byte offsets, message window at MSG + 4 * word index
`define HMB_OFF_CTRL 8'h00
`define HMB_OFF_THRESH 8'h04
`define HMB_OFF_STATUS 8'h08
`define HMB_OFF_ERRCODE 8'h0C
`define HMB_MSG_SEL 2'h1
// Control and status register fields
`define HMB_CTRL_MODE_LSB 0
`define HMB_CTRL_SAFE_BIT 2
`define HMB_CTRL_TEC_BIT 3
`define HMB_CTRL_ISU_BIT 4
`define HMB_STATUS_ERR_BIT 8
// Reset values
`define HMB_THRESH_RST 16'h0000
`define HMB_ERRCODE_RST 8'h00
// Message type and mode encodings
`define HMB_TYPE_STD 2'h0
`define HMB_TYPE_SAFE 2'h3
`define HMB_MODE_STANDBY_STATE 2'h0
`define HMB_MODE_PREPARATION_STATE 2'h1
`define HMB_MODE_MEASUREMENT_STATE 2'h2
`define HMB_MODE_BAD 2'h3
// Bus command decode
`define HMB_RT_ADDR 5'h19
`define HMB_WORD_COUNT 5'h10
`define HMB_SUBADDR_A 5'h01
`define HMB_SUBADDR_B 5'h02
`define HMB_LAST_IDX 4'hF
// Timing
`define HMB_REQ_PERIOD_S 32
`define HMB_LAT_MS 10
`define HMB_CLK_KHZ 40000
`endif

/* File: pkg/hmb_if.sv */
// Carrier between the message builder and its snapshot store
`timescale 1ns/1ps
interface hmb_if;
  import hmb_pkg::*;
  logic capture;
  hmb_word_t [15:0] live;
  logic [3:0] idx;
  hmb_word_t word;
  logic [3:0] reg_idx;
  hmb_word_t reg_word;
  modport owner(output capture, live, idx, reg_idx, input word, reg_word);
  modport store(input capture, live, idx, reg_idx, output word, reg_word);
endinterface

/* File: pkg/hmb_pkg.sv */
// Types shared by the health message builder modules
package hmb_pkg;
  typedef logic [15:0] hmb_word_t;
  typedef enum logic [2:0] {
    HMB_IDLE = 3'b001,
    HMB_STAT = 3'b010,
    HMB_DATA = 3'b100
  } hmb_state_t;
  typedef struct packed {
    hmb_state_t st;
    logic [3:0] idx;
    logic [15:0] tx_data;
    logic tx_valid;
    logic tx_last;
    logic done;
    logic [1:0] mode;
    logic safe;
    logic tec_cool;
    logic isu_pwr;
    logic [15:0] thresh;
    logic err;
    logic [7:0] err_code;
    logic [15:0] err_ts;
    logic [31:0] rd_data;
  } hmb_top_state_t;
  typedef struct packed {
    logic [7:0] count;
  } hmb_cnt_state_t;
  typedef struct packed {
    hmb_word_t [15:0] mem;
  } hmb_snap_state_t;
endpackage

/* File: verification/health_message_builder_tb_top.sv */
// Self-checking bench for the health message builder
`timescale 1ns/1ps
`include "hmb_defs.svh"
module health_message_builder_tb_top
  import hmb_pkg::*;
;
  logic clk, arst_n, reg_wr, reg_rd, err_event, err;
  logic [7:0] reg_addr, err_code, message_counter, cnt, ecode;
  logic [31:0] reg_wdata, reg_rdata, rdv;
  logic cmd_valid, tx_ready, tx_valid, tx_last;
  logic [15:0] cmd_word, tx_data, thr, ets;
  logic [4:0] ctl;
  hmb_word_t v [16];
  hmb_word_t ex [16];
  int bad_count, comparisons;

  hmb_top #(.LAT_CYCLES(16)) hmb_top_i (
    .clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .cmd_valid, .cmd_word, .tx_ready, .tx_valid, .tx_data, .tx_last,
    .photodiode_array_temp(v[1]), .cooling_console_temp(v[2]),
    .quartz_body_temp(v[3]), .sensor_board_temp(v[4]), .power_board_temp(v[5]),
    .cooler_current(v[6][15:8]), .cooler_voltage(v[6][7:0]),
    .digital_5v_voltage(v[7][15:8]), .analog_5v_voltage(v[7][7:0]),
    .rail_3v3_voltage(v[8][15:8]), .rail_1v5_voltage(v[8][7:0]),
    .digital_5v_current(v[9][15:8]), .analog_5v_current(v[9][7:0]),
    .rail_3v3_current(v[10][15:8]), .rail_1v5_current(v[10][7:0]),
    .timestamp({v[11], v[12]}), .cpu_monitor_byte_1(v[13][15:8]),
    .cpu_monitor_byte_2(v[13][7:0]), .cpu_monitor_byte_4(v[14][7:0]),
    .err_event, .err_code, .message_counter
  );
  hmb_bc_model hmb_bc_model_i (
    .clk, .cmd_valid, .cmd_word, .tx_ready, .tx_valid, .tx_data, .tx_last
  );

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic results();
    if (bad_count == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // One-cycle strobes; read data stands only in the following cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // Undefined mode is refused, so the bench keeps the old one
  task automatic set_ctl(input logic [4:0] c, input logic [15:0] t);
    ctl = (c[1:0] == 2'h3) ? {c[4:2], ctl[1:0]} : c;
    thr = t;
    wr(`HMB_OFF_CTRL, {27'h0, c});
    wr(`HMB_OFF_THRESH, {16'h0, t});
  endtask

  // Expected message from the live values and settings
  function automatic void mk();
    ex = v;
    ex[0] = {ctl[2] ? 2'h3 : 2'h0, ctl[3], ctl[4], v[4] < thr, err, ctl[1:0], cnt};
    if (err) ex[13] = ets;
    ex[14] = {err ? ecode : 8'h00, v[14][7:0]};
    ex[15] = 16'h0000;
  endfunction

  task automatic fetch_chk(input logic [15:0] cmd, input bit slow);
    int n;
    mk();
    fork
      hmb_bc_model_i.fetch(cmd, slow, n);
      // Live values move mid-transfer; the frozen copy must not
      if (slow) begin
        repeat (6) @(posedge clk);
        for (int i = 1; i < 15; i++) v[i] <= v[i] + 16'h1111;
      end
    join
    cmp(n, 17);
    cmp(hmb_bc_model_i.got[0], 16'hC800);
    for (int i = 0; i < 16; i++) cmp(hmb_bc_model_i.got[i + 1], ex[i]);
    for (int i = 0; i < 16; i++) cmp(hmb_bc_model_i.lst[i], 1'b0);
    cmp(hmb_bc_model_i.lst[16], 1'b1);
    repeat (4) @(posedge clk);
    cnt++;
    cmp(message_counter, cnt);
  endtask

  task automatic t_reset();
    cmp(message_counter, 8'h00);
    cmp(tx_valid, 1'b0);
    rd(8'h40, rdv);
    cmp(rdv, 32'h0);
  endtask

  // Every mode, both types, flag and threshold corners
  task automatic t_modes();
    logic [4:0] c [5] = '{5'h00, 5'h19, 5'h0E, 5'h12, 5'h05};
    logic [15:0] t [5] = '{16'h0000, 16'h4AB5, 16'h4AB6, 16'hFFFF, 16'h4AB4};
    for (int k = 0; k < 5; k++) begin
      set_ctl(c[k], t[k]);
      fetch_chk(k[0] ? 16'hCC50 : 16'hCC30, 1'b0);
    end
  endtask

  // Mode code 3 turned away, other control bits still land
  task automatic t_badmode();
    set_ctl(5'h1F, 16'h0000);
    fetch_chk(16'hCC30, 1'b0);
  endtask

  // Foreign or malformed commands draw no answer
  task automatic t_refuse();
    logic [15:0] bad [4] = '{16'h0C30, 16'hC830, 16'hCC2F, 16'hCC70};
    int n;
    foreach (bad[k]) begin
      hmb_bc_model_i.fetch(bad[k], 1'b0, n);
      cmp(n, 0);
    end
    cmp(message_counter, cnt);
  endtask

  // Error report replaces monitor bytes until cleared
  task automatic t_error();
    @(posedge clk);
    err_event <= 1'b1;
    err_code <= 8'h0B;
    @(posedge clk);
    err_event <= 1'b0;
    err_code <= 8'hF4;
    err = 1'b1;
    ecode = 8'h0B;
    ets = v[11];
    v[11] <= v[11] ^ 16'hFF00; // Report must keep the old stamp
    @(posedge clk); // New stamp settled before the expectation is built
    fetch_chk(16'hCC50, 1'b0);
    rd(`HMB_OFF_ERRCODE, rdv);
    cmp(rdv, {ets, 8'h00, ecode});
    wr(`HMB_OFF_STATUS, 32'h0000_0100);
    err = 1'b0;
    rd(`HMB_OFF_STATUS, rdv);
    cmp(rdv, {24'h0, cnt});
    fetch_chk(16'hCC30, 1'b0);
  endtask

  // Slow acceptance with moving inputs; snapshot readable after
  task automatic t_snap();
    fetch_chk(16'hCC30, 1'b1);
    rd(8'h44, rdv);
    cmp(rdv, {16'h0, ex[1]});
    rd(8'h20, rdv);
    cmp(rdv, 32'h0);
  endtask

  initial begin
    arst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    err_event = 1'b0;
    err_code = 8'h00;
    for (int i = 0; i < 16; i++) v[i] = {4'(i), 4'hA, 4'(15 - i), 4'h5};
    {cnt, err, ctl, thr, ecode, ets} = '0;
    bad_count = 0;
    comparisons = 0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_modes();
    t_badmode();
    t_refuse();
    t_error();
    t_snap();
    results();
  end

  // Whole run needs well under a thousand cycles; a hang ends here
  initial begin
    #(20000 * 25);
    bad_count++;
    results();
  end
endmodule

/* File: verification/hmb_bc_model.sv */
// Bus controller model that fetches the health message
`timescale 1ns/1ps
module hmb_bc_model
  import hmb_pkg::*;
(
  input wire logic clk,
  output logic cmd_valid,
  output logic [15:0] cmd_word,
  output logic tx_ready,
  input wire logic tx_valid,
  input wire logic [15:0] tx_data,
  input wire logic tx_last
);
  hmb_word_t got [17];
  logic lst [17];
  int n;
  // Quiet lines until the first fetch
  initial begin
    cmd_valid = 1'b0;
    cmd_word = 16'h0000;
    tx_ready = 1'b0;
    n = 0;
  end
  // Take a word on each edge where it is offered and accepted
  always @(posedge clk) begin
    if (tx_valid && tx_ready && n < 17) begin
      got[n] <= tx_data;
      lst[n] <= tx_last;
      n <= n + 1;
    end
  end
  // Transmit command, then ready always or every third cycle
  // Callers space the fetches, far below the nominal period
  task automatic fetch(input logic [15:0] cmd, input bit slow, output int cnt);
    int t;
    n = 0;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_word <= cmd;
    t = 0;
    while (t < 80 && n < 17) begin
      @(posedge clk);
      cmd_valid <= 1'b0;
      cmd_word <= ~cmd_word; // Unselected word keeps changing
      // Ready drops in the last pass, so it is written once per edge
      tx_ready <= (n < 17) && (t < 79) && (!slow || (t % 3 == 2));
      t++;
    end
    cnt = n;
  endtask
endmodule
